/* verilog/cpu_clock_bus_pkg.sv */
// shared constants and types for the cpu clock and bus command timing block
package cpu_clock_bus_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COMMAND_DELAY = 8'h01;
	localparam logic [7:0] OFS_BUS_CLOCK = 8'h02;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h03;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h04;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h05;

	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_ALT_RESET = 0;
	localparam int BIT_CPU_CLK_SEL = 1;
	localparam int BIT_NMI_EN = 2;
	localparam int BIT_TIMEOUT = 3;
	localparam int BIT_ADDR_HOLD = 4;
	localparam int BIT_QUICK_N = 5;
	localparam int POS_IO_DELAY = 0;
	localparam int POS_MEM8_DELAY = 2;
	localparam int POS_MEM16_DELAY = 4;
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_CPU_RESET = 1;
	localparam int IRQ_CMD_DONE = 2;
	localparam int IRQ_COUNT = 3;

	// ****************************************
	// reset values and codes
	// ****************************************
	localparam logic [5:0] CLOCK_CONTROL_RESET = 6'h20;
	localparam logic [5:0] COMMAND_DELAY_RESET = 6'h05;
	localparam logic [1:0] BUS_SRC_HALF = 2'h0;
	localparam logic [1:0] BUS_SRC_FULL = 2'h1;
	localparam logic [1:0] BUS_SRC_OSC = 2'h2;
	localparam logic [1:0] BUS_SRC_RESERVED = 2'h3;
	localparam logic [1:0] CYC_MEM16 = 2'h0;
	localparam logic [1:0] CYC_MEM8 = 2'h1;
	localparam logic [1:0] CYC_IO = 2'h2;

	// ****************************************
	// timing counts
	// ****************************************
	localparam logic [4:0] CPU_RESET_CYCLES = 5'h10;
	localparam logic [7:0] READY_TIMEOUT_CYCLES = 8'h80;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic start;
		logic [1:0] cycleType;
		logic done;
	} bus_cycle_t;

	typedef enum logic [3:0] {
		CMD_IDLE = 4'h1,
		CMD_DELAY = 4'h2,
		CMD_ACTIVE = 4'h4,
		CMD_HOLD = 4'h8
	} cmd_state_t;

endpackage : cpu_clock_bus_pkg

/* verilog/cpu_clock_bus_timing.sv */
// processor clock select, cpu reset pulse, ready timeout and bus command delays
`timescale 1ns/10ps

module cpu_clock_bus_timing (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register port
	input wire cpu_clock_bus_pkg::reg_req_t regReq,
	output logic [7:0] regRdata,
	// clock sources
	input wire logic busOscIn,
	output logic cpuClkTick,
	output logic busClkTick,
	// local bus
	input wire logic localCycleStart,
	input wire logic localReady,
	output logic cpuResetOut,
	output logic nmiOut,
	// expansion bus
	input wire cpu_clock_bus_pkg::bus_cycle_t busCycle,
	output logic busCmdOut,
	output logic busAddrValid,
	output logic busBusy,
	// memory and mode
	input wire logic twoBanksEnabled,
	output logic zeroWaitAllowed,
	output logic quickModeOn,
	// interrupt
	output logic irqOut
);

	// ****************************************
	// delay lookup
	// ****************************************
	function automatic logic [1:0] delayFor(input logic [1:0] cycleType, input logic [5:0] cfg);
		logic [1:0] d;
		d = cfg[cpu_clock_bus_pkg::POS_IO_DELAY +: 2];
		case (cycleType)
			cpu_clock_bus_pkg::CYC_MEM16: d = cfg[cpu_clock_bus_pkg::POS_MEM16_DELAY +: 2];
			cpu_clock_bus_pkg::CYC_MEM8: d = cfg[cpu_clock_bus_pkg::POS_MEM8_DELAY +: 2];
			default: d = cfg[cpu_clock_bus_pkg::POS_IO_DELAY +: 2];
		endcase
		return d;
	endfunction : delayFor

	// ****************************************
	// registers
	// ****************************************
	logic [5:0] ctrl_q;
	logic [5:0] ctrl_d;
	logic [5:0] cmdDelay_q;
	logic [1:0] busSrc_q;
	logic [2:0] irqStatus_q;
	logic [2:0] irqStatus_d;
	logic [2:0] irqEnable_q;
	logic [7:0] rdata_q;
	logic halfPhase_q;
	logic osc_q;
	logic [4:0] rstCnt_q;
	logic [4:0] rstCnt_d;
	logic [7:0] toCnt_q;
	logic [7:0] toCnt_d;
	logic waiting_q;
	logic waiting_d;
	cpu_clock_bus_pkg::cmd_state_t cmdState_q;
	cpu_clock_bus_pkg::cmd_state_t cmdState_d;
	logic [1:0] delayCnt_q;
	logic [1:0] delayCnt_d;
	logic busTick_q;
	logic cpuTick_q;
	logic zeroWait_q;

	// ****************************************
	// bus decode
	// ****************************************
	wire wrCtrl = regReq.wr && regReq.addr == cpu_clock_bus_pkg::OFS_CLOCK_CONTROL;
	wire wrDelay = regReq.wr && regReq.addr == cpu_clock_bus_pkg::OFS_COMMAND_DELAY;
	wire wrBusSrc = regReq.wr && regReq.addr == cpu_clock_bus_pkg::OFS_BUS_CLOCK;
	wire wrClear = regReq.wr && regReq.addr == cpu_clock_bus_pkg::OFS_IRQ_CLEAR;
	wire wrEnable = regReq.wr && regReq.addr == cpu_clock_bus_pkg::OFS_IRQ_ENABLE;
	wire srcReserved = regReq.wdata[1:0] == cpu_clock_bus_pkg::BUS_SRC_RESERVED;

	// ****************************************
	// clock selection
	// ****************************************
	wire oscRise = busOscIn && !osc_q;
	wire busTick = (busSrc_q == cpu_clock_bus_pkg::BUS_SRC_FULL) ? 1'b1 :
		(busSrc_q == cpu_clock_bus_pkg::BUS_SRC_OSC) ? oscRise : halfPhase_q;
	wire cpuTick = ctrl_q[cpu_clock_bus_pkg::BIT_CPU_CLK_SEL] ? busTick : 1'b1;

	// ****************************************
	// cpu reset pulse
	// ****************************************
	wire resetActive = rstCnt_q != 5'h00;
	wire altRise = wrCtrl && regReq.wdata[cpu_clock_bus_pkg::BIT_ALT_RESET]
		&& !ctrl_q[cpu_clock_bus_pkg::BIT_ALT_RESET];
	wire resetStart = altRise && !resetActive;
	wire resetEnd = resetActive && cpuTick && rstCnt_q == 5'h01;

	always_comb begin
		rstCnt_d = rstCnt_q;
		if (resetStart) begin
			rstCnt_d = cpu_clock_bus_pkg::CPU_RESET_CYCLES;
		end else if (resetActive && cpuTick) begin
			rstCnt_d = rstCnt_q - 5'h01;
		end
	end

	// ****************************************
	// ready timeout
	// ****************************************
	wire timeoutHit = waiting_q && cpuTick && !localReady
		&& toCnt_q == cpu_clock_bus_pkg::READY_TIMEOUT_CYCLES - 8'h01;

	always_comb begin
		toCnt_d = toCnt_q;
		waiting_d = waiting_q;
		if (localCycleStart) begin
			toCnt_d = 8'h00;
			waiting_d = 1'b1;
		end else if (waiting_q && (localReady || timeoutHit)) begin
			waiting_d = 1'b0;
		end else if (waiting_q && cpuTick) begin
			toCnt_d = toCnt_q + 8'h01;
		end
	end

	// ****************************************
	// command sequencer
	// ****************************************
	wire [1:0] startDelay = delayFor(busCycle.cycleType, cmdDelay_q);
	wire holdOn = ctrl_q[cpu_clock_bus_pkg::BIT_ADDR_HOLD];
	wire cmdDone = (cmdState_q == cpu_clock_bus_pkg::CMD_ACTIVE && busCycle.done && !holdOn)
		|| (cmdState_q == cpu_clock_bus_pkg::CMD_HOLD && busTick);

	always_comb begin
		cmdState_d = cmdState_q;
		delayCnt_d = delayCnt_q;
		case (cmdState_q)
			cpu_clock_bus_pkg::CMD_IDLE: begin
				if (busCycle.start) begin
					delayCnt_d = startDelay;
					cmdState_d = (startDelay == 2'h0) ? cpu_clock_bus_pkg::CMD_ACTIVE : cpu_clock_bus_pkg::CMD_DELAY;
				end
			end
			cpu_clock_bus_pkg::CMD_DELAY: begin
				if (busTick) begin
					delayCnt_d = delayCnt_q - 2'h1;
					if (delayCnt_q == 2'h1) begin
						cmdState_d = cpu_clock_bus_pkg::CMD_ACTIVE;
					end
				end
			end
			cpu_clock_bus_pkg::CMD_ACTIVE: begin
				if (busCycle.done) begin
					cmdState_d = holdOn ? cpu_clock_bus_pkg::CMD_HOLD : cpu_clock_bus_pkg::CMD_IDLE;
				end
			end
			cpu_clock_bus_pkg::CMD_HOLD: begin
				if (busTick) begin
					cmdState_d = cpu_clock_bus_pkg::CMD_IDLE;
				end
			end
			default: begin
				cmdState_d = cpu_clock_bus_pkg::CMD_IDLE;
			end
		endcase
	end

	// ****************************************
	// register writes
	// ****************************************
	always_comb begin
		ctrl_d = ctrl_q;
		if (wrCtrl) begin
			ctrl_d = regReq.wdata[5:0];
		end
		ctrl_d[cpu_clock_bus_pkg::BIT_TIMEOUT] = irqStatus_d[cpu_clock_bus_pkg::IRQ_TIMEOUT];
	end

	// ****************************************
	// interrupt status
	// ****************************************
	wire [2:0] irqSet = {cmdDone, resetEnd, timeoutHit};
	wire [2:0] irqClr = wrClear ? regReq.wdata[2:0] : 3'h0;

	genvar gi;
	generate
		for (gi = 0; gi < cpu_clock_bus_pkg::IRQ_COUNT; gi++) begin : g_irq
			assign irqStatus_d[gi] = irqSet[gi] || (irqStatus_q[gi] && !irqClr[gi]);
		end
	endgenerate

	// ****************************************
	// read mux
	// ****************************************
	wire [7:0] rdMux =
		(regReq.addr == cpu_clock_bus_pkg::OFS_CLOCK_CONTROL) ? {2'h0, ctrl_q} :
		(regReq.addr == cpu_clock_bus_pkg::OFS_COMMAND_DELAY) ? {2'h0, cmdDelay_q} :
		(regReq.addr == cpu_clock_bus_pkg::OFS_BUS_CLOCK) ? {6'h00, busSrc_q} :
		(regReq.addr == cpu_clock_bus_pkg::OFS_IRQ_STATUS) ? {5'h00, irqStatus_q} :
		(regReq.addr == cpu_clock_bus_pkg::OFS_IRQ_ENABLE) ? {5'h00, irqEnable_q} : 8'h00;

	// ****************************************
	// flops
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q <= cpu_clock_bus_pkg::CLOCK_CONTROL_RESET;
			cmdDelay_q <= cpu_clock_bus_pkg::COMMAND_DELAY_RESET;
			busSrc_q <= cpu_clock_bus_pkg::BUS_SRC_HALF;
			irqStatus_q <= 3'h0;
			irqEnable_q <= 3'h0;
			rdata_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			irqStatus_q <= irqStatus_d;
			rdata_q <= regReq.rd ? rdMux : 8'h00;
			if (wrDelay) begin
				cmdDelay_q <= regReq.wdata[5:0];
			end
			if (wrBusSrc && !srcReserved) begin
				busSrc_q <= regReq.wdata[1:0];
			end
			if (wrEnable) begin
				irqEnable_q <= regReq.wdata[2:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			halfPhase_q <= 1'b0;
			osc_q <= 1'b0;
			rstCnt_q <= 5'h00;
			toCnt_q <= 8'h00;
			waiting_q <= 1'b0;
		end else begin
			halfPhase_q <= !halfPhase_q;
			osc_q <= busOscIn;
			rstCnt_q <= rstCnt_d;
			toCnt_q <= toCnt_d;
			waiting_q <= waiting_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmdState_q <= cpu_clock_bus_pkg::CMD_IDLE;
			delayCnt_q <= 2'h0;
			busTick_q <= 1'b0;
			cpuTick_q <= 1'b0;
			zeroWait_q <= 1'b0;
		end else begin
			cmdState_q <= cmdState_d;
			delayCnt_q <= delayCnt_d;
			busTick_q <= busTick;
			cpuTick_q <= cpuTick;
			zeroWait_q <= twoBanksEnabled;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign regRdata = rdata_q;
	assign busClkTick = busTick_q;
	assign cpuClkTick = cpuTick_q;
	assign cpuResetOut = resetActive;
	assign nmiOut = ctrl_q[cpu_clock_bus_pkg::BIT_TIMEOUT] && ctrl_q[cpu_clock_bus_pkg::BIT_NMI_EN];
	assign busCmdOut = cmdState_q == cpu_clock_bus_pkg::CMD_ACTIVE;
	assign busAddrValid = cmdState_q != cpu_clock_bus_pkg::CMD_IDLE;
	assign busBusy = cmdState_q != cpu_clock_bus_pkg::CMD_IDLE;
	assign zeroWaitAllowed = zeroWait_q;
	assign quickModeOn = !ctrl_q[cpu_clock_bus_pkg::BIT_QUICK_N];
	assign irqOut = |(irqStatus_q & irqEnable_q);

endmodule : cpu_clock_bus_timing

/* test/cpu_clock_bus_timing_assertions.sv */
// port assertions for the cpu clock and bus command timing block
`timescale 1ns/10ps
module cpu_clock_bus_timing_assertions (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// watched ports
	input wire cpu_clock_bus_pkg::reg_req_t regReq,
	input wire logic [7:0] regRdata,
	input wire logic localCycleStart,
	input wire logic localReady,
	input wire logic cpuResetOut,
	input wire logic nmiOut,
	input wire cpu_clock_bus_pkg::bus_cycle_t busCycle,
	input wire logic busCmdOut,
	input wire logic busAddrValid,
	input wire logic busBusy,
	input wire logic twoBanksEnabled,
	input wire logic zeroWaitAllowed,
	input wire logic quickModeOn
);
	// ****
	// helpers
	// ****
	logic altBit_q;
	logic [4:0] pulseLen_q;
	logic [7:0] quiet_q;
	wire ctrlHit = regReq.wr && regReq.addr == cpu_clock_bus_pkg::OFS_CLOCK_CONTROL;
	always_ff @(posedge clk_sys) begin
		altBit_q <= rst ? 1'b0 : (ctrlHit ? regReq.wdata[0] : altBit_q);
	end
	always_ff @(posedge clk_sys) begin
		pulseLen_q <= (rst || !cpuResetOut) ? 5'h00 : pulseLen_q + 5'h01;
	end
	always_ff @(posedge clk_sys) begin
		quiet_q <= (rst || localCycleStart || localReady) ? 8'h00 : (quiet_q == 8'hFF ? quiet_q : quiet_q + 8'h01);
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence ctrlWrite;
		ctrlHit;
	endsequence
	sequence trigRise;
		ctrlWrite ##0 (regReq.wdata[0] && !altBit_q && !cpuResetOut);
	endsequence
	// ****
	// checks
	// ****
	chk_reset_start: assert property (trigRise |=> cpuResetOut)
		else $error("cpu reset did not start");
	chk_reset_steady: assert property (ctrlWrite ##0 (!cpuResetOut && (!regReq.wdata[0] || altBit_q)) |=> !cpuResetOut)
		else $error("cpu reset started without a rise");
	chk_reset_length: assert property ($fell(cpuResetOut) |-> pulseLen_q == 5'h10)
		else $error("cpu reset length wrong");
	chk_unmapped_zero: assert property (regReq.rd && regReq.addr > 8'h05 |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	chk_nmi_cause: assert property ($rose(nmiOut) |-> quiet_q >= 8'h7F || $past(regReq.wr))
		else $error("nmi without timeout");
	chk_quick_write: assert property (ctrlWrite |=> quickModeOn == !$past(regReq.wdata[5]))
		else $error("quick mode wrong");
	chk_zero_wait: assert property (!$past(rst) |-> zeroWaitAllowed == $past(twoBanksEnabled))
		else $error("zero wait flag wrong");
	chk_cmd_ends: assert property (busCmdOut && busCycle.done |=> !busCmdOut)
		else $error("command did not end");
	chk_cmd_addr: assert property (busCmdOut |-> busBusy && busAddrValid)
		else $error("command without address");
	chk_start_busy: assert property (busCycle.start && !busBusy |=> busBusy)
		else $error("start not taken");
endmodule : cpu_clock_bus_timing_assertions

bind cpu_clock_bus_timing cpu_clock_bus_timing_assertions cpu_clock_bus_timing_assertions_i (.clk_sys(clk_sys),
	.rst(rst), .regReq(regReq), .regRdata(regRdata), .localCycleStart(localCycleStart), .localReady(localReady),
	.cpuResetOut(cpuResetOut), .nmiOut(nmiOut), .busCycle(busCycle), .busCmdOut(busCmdOut),
	.busAddrValid(busAddrValid), .busBusy(busBusy), .twoBanksEnabled(twoBanksEnabled),
	.zeroWaitAllowed(zeroWaitAllowed), .quickModeOn(quickModeOn));

/* test/bus_partner_model.sv */
// far side model: local bus ready source and expansion card completion
`timescale 1ns/10ps
module bus_partner_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// behaviour
	input wire logic answerOn,
	input wire logic [3:0] waitLen,
	// local bus
	input wire logic localCycleStart,
	output logic localReady,
	// expansion bus
	input wire logic busCmdOut,
	output logic cmdDone
);
	logic [4:0] readyCnt_q;
	logic [3:0] cmdCnt_q;
	always_ff @(posedge clk_sys) begin
		if (rst) readyCnt_q <= 5'h00;
		else if (localCycleStart && answerOn) readyCnt_q <= {1'b0, waitLen} + 5'h02;
		else if (readyCnt_q != 5'h00) readyCnt_q <= readyCnt_q - 5'h01;
	end
	always_ff @(posedge clk_sys) begin
		cmdCnt_q <= (rst || !busCmdOut) ? 4'h0 : cmdCnt_q + 4'h1;
	end
	assign localReady = readyCnt_q == 5'h01;
	assign cmdDone = busCmdOut && cmdCnt_q == waitLen;
endmodule : bus_partner_model

/* test/test_cpu_clock_bus_timing.sv */
// self-checking bench for the cpu clock and bus command timing block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module test_cpu_clock_bus_timing;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	cpu_clock_bus_pkg::reg_req_t regReq = '0;
	cpu_clock_bus_pkg::bus_cycle_t busCycle;
	logic [7:0] regRdata;
	logic busOscIn = 1'b0, cpuClkTick, busClkTick, localCycleStart = 1'b0, localReady, cpuResetOut, nmiOut;
	logic busStart = 1'b0, cmdDone, busCmdOut, busAddrValid, busBusy, zeroWaitAllowed, quickModeOn, irqOut;
	logic twoBanksEnabled = 1'b0, answerOn = 1'b1;
	logic [1:0] busType = 2'h0;
	logic [7:0] d;
	int n_fail = 0, n_compared = 0, n, cc, bc;
	assign busCycle = {busStart, busType, cmdDone};
	cpu_clock_bus_timing cpu_clock_bus_timing_i (.clk_sys(clk_sys), .rst(rst), .regReq(regReq),
		.regRdata(regRdata), .busOscIn(busOscIn), .cpuClkTick(cpuClkTick), .busClkTick(busClkTick),
		.localCycleStart(localCycleStart), .localReady(localReady), .cpuResetOut(cpuResetOut), .nmiOut(nmiOut),
		.busCycle(busCycle), .busCmdOut(busCmdOut), .busAddrValid(busAddrValid), .busBusy(busBusy),
		.twoBanksEnabled(twoBanksEnabled), .zeroWaitAllowed(zeroWaitAllowed), .quickModeOn(quickModeOn),
		.irqOut(irqOut));
	bus_partner_model bus_partner_model_i (.clk_sys(clk_sys), .rst(rst), .answerOn(answerOn), .waitLen(4'h2),
		.localCycleStart(localCycleStart), .localReady(localReady), .busCmdOut(busCmdOut), .cmdDone(cmdDone));
	initial forever #50 clk_sys = ~clk_sys;
	initial forever begin repeat (3) @(posedge clk_sys); busOscIn <= ~busOscIn; end
	initial begin #3000000; n_fail++; end_of_test; end
	// ****
	// tasks
	// ****
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys); regReq <= {a, v, 2'b10};
		@(posedge clk_sys); regReq.wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
		@(posedge clk_sys); regReq <= {a, 8'h00, 2'b01};
		@(posedge clk_sys); regReq.rd <= 1'b0;
		@(negedge clk_sys); `CHK(nm, ex, regRdata)
	endtask : rd
	task count(input int len);
		// first sample still shows the tick of the old setting
		cc = 0; bc = 0; @(negedge clk_sys);
		repeat (len) begin @(negedge clk_sys); cc += int'(cpuClkTick); bc += int'(busClkTick); end
	endtask : count
	task pulse;
		@(posedge clk_sys); localCycleStart <= 1'b1;
		@(posedge clk_sys); localCycleStart <= 1'b0;
	endtask : pulse
	task end_of_test;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// ****
	// tests
	// ****
	initial begin
		repeat (2) @(posedge clk_sys); rst <= 1'b0;
		rd(8'h00, 8'h20, "control");
		rd(8'h01, 8'h05, "delays");
		rd(8'h02, 8'h00, "source");
		rd(8'h07, 8'h00, "unmapped");
		wr(8'h00, 8'hC0); rd(8'h00, 8'h00, "reserved");
		`CHK("quick", 1'b1, quickModeOn)
		wr(8'h00, 8'h20); twoBanksEnabled <= 1'b1; count(2);
		`CHK("zerowait", 1'b1, zeroWaitAllowed)
		$display("test registers done");
		for (int s = 0; s < 3; s++) begin wr(8'h02, 8'(s)); count(24); `CHK("bustick", s == 0 ? 12 : s == 1 ? 24 : 4, bc) end
		wr(8'h02, 8'h03); rd(8'h02, 8'h02, "srcres");
		wr(8'h02, 8'h00); wr(8'h00, 8'h22); count(24); `CHK("cpuslow", 12, cc)
		wr(8'h00, 8'h20); count(24); `CHK("cpufast", 24, cc)
		$display("test clocks done");
		wr(8'h00, 8'h21); wr(8'h00, 8'h20); wr(8'h00, 8'h21); n = 0;
		repeat (20) begin @(negedge clk_sys); n += int'(cpuResetOut); end
		`CHK("pulse", 12, n)
		rd(8'h03, 8'h02, "status"); `CHK("masked", 1'b0, irqOut)
		wr(8'h05, 8'h07); count(2); `CHK("irq", 1'b1, irqOut)
		wr(8'h04, 8'h02); count(2); `CHK("irqclr", 1'b0, irqOut)
		wr(8'h00, 8'h24); pulse; count(200); `CHK("ready", 1'b0, nmiOut)
		answerOn <= 1'b0; pulse; count(100); pulse; count(120); `CHK("early", 1'b0, nmiOut)
		count(20); `CHK("nmi", 1'b1, nmiOut)
		rd(8'h00, 8'h2C, "flag");
		wr(8'h00, 8'h20); count(2); `CHK("nmioff", 1'b0, nmiOut)
		wr(8'h04, 8'h01); rd(8'h03, 8'h00, "cleared");
		$display("test reset and timeout done");
		wr(8'h02, 8'h01);
		for (int k = 0; k < 2; k++) begin
			d = k == 0 ? 8'h38 : 8'h06; wr(8'h01, d); wr(8'h00, k == 0 ? 8'h20 : 8'h30);
			for (int t = 0; t < 4; t++) begin
				@(posedge clk_sys); busStart <= 1'b1; busType <= 2'(t);
				@(posedge clk_sys); busStart <= 1'b0; n = 0; @(negedge clk_sys);
				while (!busCmdOut && n < 10) begin n++; @(negedge clk_sys); end
				`CHK("delay", t == 0 ? d[5:4] : t == 1 ? d[3:2] : d[1:0], 2'(n))
				while (busCmdOut && n < 30) begin n++; @(negedge clk_sys); end
				`CHK("hold", 1'(k), busAddrValid)
				count(6);
			end
		end
		rd(8'h03, 8'h04, "cmddone");
		@(posedge clk_sys); twoBanksEnabled <= 1'b0; count(2);
		`CHK("zerowait0", 1'b0, zeroWaitAllowed)
		$display("test commands done");
		end_of_test;
	end
endmodule : test_cpu_clock_bus_timing
